// ===== logic/acc_config_control.sv
// Purpose: strap decode, serial register writes and pin/register priority
// Assumes: serial pins far slower than clk_in; clk_in samples them
// Notes:   settings output is registered and always valid after reset
`timescale 1ns/1ps
module acc_config_control
  import acc_pkg::*;
(
  // clock and reset
  input  wire logic          clk_in,
  input  wire logic          resetn_in,
  input  wire logic          clk_en_in,
  // mode and register reset
  input  wire logic          parallel_mode_in,
  input  wire logic          reg_reset_in,
  // serial port
  input  wire logic          serial_enable_n,
  input  wire logic          serial_clk_in,
  input  wire logic          serial_data_in,
  // strap and power-down pins
  input  wire acc_straps_t   straps_in,
  input  wire logic [1:0]    strap_reserved_in,
  input  wire logic          pdn_pin_in,
  // decoded configuration
  output acc_settings_t      settings_out,
  output logic               write_done_out
);

  // synchronisers
  logic [1:0]  sen_s_q;
  logic [1:0]  sclk_s_q;
  logic [1:0]  sdat_s_q;
  logic [1:0]  pmode_s_q;
  logic [1:0]  pdn_s_q;
  acc_straps_t straps_s1_q;
  acc_straps_t straps_s2_q;
  logic        rst_catch_q;
  logic [1:0]  rst_s_q;

  // serial engine
  logic                  sclk_prev_q;
  logic [3:0]            bit_cnt_q;
  logic [WORD_BITS-1:0]  shift_q;
  logic [WORD_BITS-1:0]  shift_d;
  logic                  fall_edge;
  logic                  word_done;

  // delayed commit
  logic                  pend_q;
  logic [WORD_BITS-1:0]  pend_word_q;
  logic [3:0]            pend_cnt_q;
  logic                  commit;
  logic [ADDR_BITS-1:0]  commit_addr;
  logic [DATA_BITS-1:0]  commit_data;
  logic                  soft_reset;

  // registers
  logic [DATA_BITS-1:0]  main_q;
  logic [DATA_BITS-1:0]  format_q;
  logic [DATA_BITS-1:0]  iface_q;
  logic                  regs_clear;

  // decode
  acc_settings_t         settings_d;
  logic                  override;
  logic                  s_ref;
  logic                  s_gain;
  logic                  s_two_wire;
  logic                  s_ddr;
  logic                  s_14x;
  logic                  s_rise;
  logic                  s_lsb;
  logic                  s_offset;
  logic                  sel_two_wire;
  logic                  sel_ddr;
  acc_pattern_t          reg_pattern;

  // reset pin pulse may be shorter than a clock period
  always_ff @(posedge clk_in or posedge reg_reset_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_catch_q <= 1'b0;
    end else if (reg_reset_in) begin
      rst_catch_q <= 1'b1;
    end else if (clk_en_in && rst_s_q[1]) begin
      rst_catch_q <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      rst_s_q <= 2'h0;
    end else if (clk_en_in) begin
      rst_s_q <= {rst_s_q[0], rst_catch_q};
    end
  end

  // pin synchronisers
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sen_s_q     <= 2'h3;
      sclk_s_q    <= 2'h0;
      sdat_s_q    <= 2'h0;
      pmode_s_q   <= 2'h0;
      pdn_s_q     <= 2'h0;
      straps_s1_q <= '0;
      straps_s2_q <= '0;
    end else if (clk_en_in) begin
      sen_s_q     <= {sen_s_q[0], serial_enable_n};
      sclk_s_q    <= {sclk_s_q[0], serial_clk_in};
      sdat_s_q    <= {sdat_s_q[0], serial_data_in};
      pmode_s_q   <= {pmode_s_q[0], parallel_mode_in};
      pdn_s_q     <= {pdn_s_q[0], pdn_pin_in};
      straps_s1_q <= straps_in;
      straps_s2_q <= straps_s1_q;
    end
  end

  // falling edge found by sampling, duty cycle free
  assign fall_edge = sclk_prev_q & ~sclk_s_q[1] & ~sen_s_q[1] & ~pmode_s_q[1];
  assign word_done = fall_edge && (bit_cnt_q == LAST_BIT);
  // msb first, new bit enters at the bottom
  assign shift_d   = {shift_q[WORD_BITS-2:0], sdat_s_q[1]};

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      sclk_prev_q <= 1'b0;
    end else if (clk_en_in) begin
      sclk_prev_q <= sclk_s_q[1];
    end
  end

  // count clears while enable high, dropping partial words
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      bit_cnt_q <= 4'h0;
      shift_q   <= '0;
    end else if (clk_en_in) begin
      if (sen_s_q[1] || pmode_s_q[1]) begin
        bit_cnt_q <= 4'h0;
      end else if (fall_edge) begin
        bit_cnt_q <= bit_cnt_q + 4'h1;
        shift_q   <= shift_d;
      end
    end
  end

  // completed word waits the settling delay before commit
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      pend_q      <= 1'b0;
      pend_word_q <= '0;
      pend_cnt_q  <= 4'h0;
    end else if (clk_en_in) begin
      if (word_done) begin
        pend_q      <= 1'b1;
        pend_word_q <= shift_d;
        pend_cnt_q  <= 4'(EFFECT_CYC - 1);
      end else if (pend_q) begin
        if (pend_cnt_q == 4'h0) begin
          pend_q <= 1'b0;
        end else begin
          pend_cnt_q <= pend_cnt_q - 4'h1;
        end
      end
    end
  end

  assign commit      = pend_q && (pend_cnt_q == 4'h0) && !word_done;
  assign commit_addr = pend_word_q[WORD_BITS-1 -: ADDR_BITS];
  assign commit_data = pend_word_q[DATA_BITS-1:0];
  // soft reset bit is never stored
  assign soft_reset  = commit && (commit_addr == ADDR_MAIN) && commit_data[F_SOFT_RESET];
  assign regs_clear  = soft_reset || rst_s_q[1];

  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      write_done_out <= 1'b0;
    end else if (clk_en_in) begin
      write_done_out <= commit;
    end
  end

  // register file, reset from pin pulse or soft reset
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      main_q   <= RST_MAIN;
      format_q <= RST_FORMAT;
      iface_q  <= RST_IFACE;
    end else if (clk_en_in) begin
      if (regs_clear) begin
        main_q   <= RST_MAIN;
        format_q <= RST_FORMAT;
        iface_q  <= RST_IFACE;
      end else if (commit) begin
        unique case (commit_addr)
          ADDR_MAIN: begin
            main_q <= commit_data;
          end
          ADDR_FORMAT: begin
            format_q <= commit_data;
          end
          ADDR_IFACE: begin
            iface_q <= commit_data;
          end
          default: begin
          end
        endcase
      end
    end
  end

  // first strap: bit clock rate and wire count
  always_comb begin
    sel_two_wire = 1'b0;
    sel_ddr      = 1'b1;
    unique case (straps_s2_q.interface_sel)
      LVL_0: begin
        sel_two_wire = 1'b0;
        sel_ddr      = 1'b1;
      end
      LVL_1: begin
        sel_two_wire = 1'b0;
        sel_ddr      = 1'b1;
      end
      LVL_2: begin
        sel_two_wire = 1'b1;
        sel_ddr      = 1'b0;
      end
      LVL_3: begin
        sel_two_wire = 1'b1;
        sel_ddr      = 1'b1;
      end
    endcase
  end

  assign override = iface_q[F_OVERRIDE];

  always_comb begin
    reg_pattern = PAT_NORMAL;
    unique case (format_q[F_PATTERN_LO +: 2])
      2'h1: begin
        reg_pattern = PAT_SYNC;
      end
      2'h2: begin
        reg_pattern = PAT_DESKEW;
      end
      default: begin
        reg_pattern = PAT_NORMAL;
      end
    endcase
  end

  // straps decide unless override is set
  always_comb begin
    s_two_wire = sel_two_wire;
    s_ddr      = sel_ddr;
    // 12x on outer levels, rising edge on upper levels
    s_14x      = (straps_s2_q.serialize_sel == LVL_1) ||
                 (straps_s2_q.serialize_sel == LVL_2);
    s_rise     = straps_s2_q.serialize_sel[1];
    // lsb first on upper levels, offset binary on middle ones
    s_lsb      = straps_s2_q.format_sel[1];
    s_offset   = (straps_s2_q.format_sel == LVL_1) ||
                 (straps_s2_q.format_sel == LVL_2);
    if (override) begin
      s_two_wire = iface_q[F_TWO_WIRE];
      s_ddr      = iface_q[F_DDR];
      s_14x      = iface_q[F_SER_14X];
      s_rise     = iface_q[F_RISE_EDGE];
      s_lsb      = iface_q[F_LSB_FIRST];
      s_offset   = format_q[F_DATA_FMT];
    end
  end

  // enable level: upper half internal, middle levels 3.5 dB
  // serial mode gain only with override, else 0 dB
  always_comb begin
    if (pmode_s_q[1]) begin
      s_ref  = straps_s2_q.enable_level[1];
      s_gain = (straps_s2_q.enable_level == LVL_1) ||
               (straps_s2_q.enable_level == LVL_2);
    end else begin
      // reference from register in serial mode
      s_ref  = main_q[F_REF];
      s_gain = override & iface_q[F_COARSE];
    end
  end

  always_comb begin
    settings_d               = '0;
    settings_d.ref_internal  = s_ref;
    settings_d.gain_3p5db    = s_gain;
    settings_d.two_wire      = s_two_wire;
    settings_d.ddr_clock     = s_ddr;
    settings_d.ser_14x       = s_14x;
    // capture edge only meaningful in two-wire single rate
    settings_d.capture_rise  = s_rise & s_two_wire & ~s_ddr;
    settings_d.lsb_first     = s_lsb;
    settings_d.offset_binary = s_offset;
    settings_d.byte_wise     = override & iface_q[F_BYTE_WISE];
    settings_d.pdn_channel   = main_q[F_PDN_CH_LO +: 4];
    if (pmode_s_q[1]) begin
      // clock and data pins as levels
      unique case ({sclk_s_q[1], sdat_s_q[1]})
        2'b00: begin
          settings_d.pattern    = PAT_NORMAL;
          settings_d.pdn_global = pdn_s_q[1];
        end
        2'b01: begin
          settings_d.pattern    = PAT_SYNC;
          settings_d.pdn_global = pdn_s_q[1];
        end
        2'b10: begin
          settings_d.pattern    = PAT_NORMAL;
          settings_d.pdn_global = 1'b1;
        end
        2'b11: begin
          settings_d.pattern    = PAT_DESKEW;
          settings_d.pdn_global = pdn_s_q[1];
        end
      endcase
      settings_d.pdn_channel = 4'h0;
    end else begin
      // patterns and power down from registers
      settings_d.pattern    = reg_pattern;
      // pin high forces power down over the register bit
      settings_d.pdn_global = pdn_s_q[1] | main_q[F_PDN_GLOBAL];
    end
  end

  // outputs clear to zero in reset, then follow the registered decode
  always_ff @(posedge clk_in or negedge resetn_in) begin
    if (!resetn_in) begin
      settings_out <= '0;
    end else if (clk_en_in) begin
      settings_out <= settings_d;
    end
  end

endmodule

// ===== logic/acc_pkg.sv
// Purpose: constants and types for the adc configuration front end
// Assumes: strap and enable pins arrive as 2-bit level codes, 0 lowest
// Notes:   serial word is address then data, both msb first
// How it works
// - shift only while serial_enable_n low
// - data sampled on falling serial clock
// - sixteenth falling edge writes addressed register
// - many words per frame, leftovers dropped
// - five address bits then eleven data
// - soft reset bit restores defaults, self-clears
// - straps configure device without any reset
// - override bit selects registers over straps
// - power-down pin forces global power down
// - coarse gain needs override, else 0 dB
// - serial mode: ref, patterns, pdn from registers
// - pin mode: clock/data pick output pattern
// - pin mode: clock high data low powers down
// - enable level picks reference and gain
// - first strap picks bit clock and wires
// - second strap picks serialization and edge
// - third strap picks bit order, format
// - write takes effect about 100 ns later
package acc_pkg;

  // timing
  localparam int unsigned CLK_PERIOD_NS = 100;
  localparam int unsigned EFFECT_NS     = 100;
  localparam int unsigned EFFECT_CYC    = (EFFECT_NS / CLK_PERIOD_NS) < 1 ?
                                          1 : (EFFECT_NS / CLK_PERIOD_NS);

  // serial word layout
  localparam int unsigned WORD_BITS = 16;
  localparam int unsigned ADDR_BITS = 5;
  localparam int unsigned DATA_BITS = 11;
  localparam logic [3:0]  LAST_BIT  = 4'hF;

  // register addresses
  localparam logic [4:0] ADDR_MAIN   = 5'h00;
  localparam logic [4:0] ADDR_FORMAT = 5'h0A;
  localparam logic [4:0] ADDR_IFACE  = 5'h0D;

  // register 0x00 fields
  localparam int unsigned F_SOFT_RESET = 10;
  localparam int unsigned F_REF        = 5;
  localparam int unsigned F_PDN_CH_LO  = 1;
  localparam int unsigned F_PDN_GLOBAL = 0;
  // register 0x0A fields
  localparam int unsigned F_DATA_FMT   = 10;
  localparam int unsigned F_PATTERN_LO = 5;
  // register 0x0D fields
  localparam int unsigned F_OVERRIDE   = 10;
  localparam int unsigned F_BYTE_WISE  = 7;
  localparam int unsigned F_LSB_FIRST  = 6;
  localparam int unsigned F_COARSE     = 5;
  localparam int unsigned F_RISE_EDGE  = 4;
  localparam int unsigned F_SER_14X    = 2;
  localparam int unsigned F_DDR        = 1;
  localparam int unsigned F_TWO_WIRE   = 0;

  // reset values
  localparam logic [10:0] RST_MAIN   = 11'h000;
  localparam logic [10:0] RST_FORMAT = 11'h000;
  localparam logic [10:0] RST_IFACE  = 11'h000;

  // strap level codes
  localparam logic [1:0] LVL_0 = 2'h0;
  localparam logic [1:0] LVL_1 = 2'h1;
  localparam logic [1:0] LVL_2 = 2'h2;
  localparam logic [1:0] LVL_3 = 2'h3;

  typedef enum logic [1:0] {
    PAT_NORMAL,
    PAT_SYNC,
    PAT_DESKEW
  } acc_pattern_t;

  typedef struct packed {
    logic [1:0] enable_level;
    logic [1:0] interface_sel;
    logic [1:0] serialize_sel;
    logic [1:0] format_sel;
  } acc_straps_t;

  typedef struct packed {
    logic         pdn_global;
    logic [3:0]   pdn_channel;
    logic         ref_internal;
    logic         gain_3p5db;
    logic         two_wire;
    logic         ddr_clock;
    logic         ser_14x;
    logic         capture_rise;
    logic         lsb_first;
    logic         offset_binary;
    logic         byte_wise;
    acc_pattern_t pattern;
  } acc_settings_t;

endpackage

// ===== testbench/acc_config_control_props.sv
// Purpose: port assertions for acc_config_control
// Assumes: checks pause while clk_en_in low
// Notes:   pin checks allow five cycles for synchronisers
`timescale 1ns/1ps
module acc_config_control_props
  import acc_pkg::*;
(
  // clock and reset
  input wire logic          clk_in,
  input wire logic          resetn_in,
  input wire logic          clk_en_in,
  // mode and serial port
  input wire logic          parallel_mode_in,
  input wire logic          reg_reset_in,
  input wire logic          serial_enable_n,
  input wire logic          serial_clk_in,
  input wire logic          serial_data_in,
  // pins
  input wire acc_straps_t   straps_in,
  input wire logic [1:0]    strap_reserved_in,
  input wire logic          pdn_pin_in,
  // outputs
  input wire acc_settings_t settings_out,
  input wire logic          write_done_out
);
  default clocking @(posedge clk_in);
  endclocking
  default disable iff (!resetn_in || !clk_en_in);

  sequence quiet_s;
    (serial_enable_n || parallel_mode_in) [*8];
  endsequence
  sequence pins_s(logic c, logic d);
    (parallel_mode_in && serial_clk_in == c && serial_data_in == d) [*5];
  endsequence

  pdn_pin_a: assert property (pdn_pin_in [*5] |-> settings_out.pdn_global)
    else $error("power-down pin not forcing power down");
  pin_pdn_a: assert property (pins_s(1'h1, 1'h0) |-> settings_out.pdn_global)
    else $error("pin mode power down missing");
  sync_pat_a: assert property (pins_s(1'h0, 1'h1) |-> settings_out.pattern == PAT_SYNC)
    else $error("pin mode sync pattern missing");
  deskew_pat_a: assert property (pins_s(1'h1, 1'h1) |-> settings_out.pattern == PAT_DESKEW)
    else $error("pin mode deskew pattern missing");
  level_dec_a: assert property ((parallel_mode_in && $stable(straps_in)) [*5] |->
    settings_out.ref_internal == straps_in.enable_level[1] &&
    settings_out.gain_3p5db == ^straps_in.enable_level)
    else $error("enable level decode wrong");
  quiet_port_a: assert property (quiet_s |-> !write_done_out)
    else $error("write done with port idle");
  done_cause_a: assert property (write_done_out |->
    !$past(serial_enable_n, 3) && !$past(parallel_mode_in, 3))
    else $error("write done without enabled frame");
  done_gap_a: assert property (write_done_out |=> !write_done_out [*8])
    else $error("write done pulses too close");
  reset_out_a: assert property (disable iff (1'h0) !resetn_in |->
    settings_out == '0 && !write_done_out)
    else $error("outputs not cleared in reset");
endmodule

bind acc_config_control acc_config_control_props u_props (
  .clk_in(clk_in), .resetn_in(resetn_in), .clk_en_in(clk_en_in),
  .parallel_mode_in(parallel_mode_in), .reg_reset_in(reg_reset_in),
  .serial_enable_n(serial_enable_n), .serial_clk_in(serial_clk_in),
  .serial_data_in(serial_data_in), .straps_in(straps_in),
  .strap_reserved_in(strap_reserved_in), .pdn_pin_in(pdn_pin_in),
  .settings_out(settings_out), .write_done_out(write_done_out)
);

// ===== testbench/acc_host_model.sv
// Purpose: host driving the serial configuration port
// Assumes: driven from clk_in edges
// Notes:   released data line toggles every cycle
`timescale 1ns/1ps
module acc_host_model (
  // clock
  input  wire logic clk_in,
  // serial pins
  output logic      sen_n_out,
  output logic      sclk_out,
  output logic      serial_data_in_out
);
  bit pin_q = 1'h1;

  initial begin
    sen_n_out = 1'h1;
    sclk_out = 1'h0;
    serial_data_in_out = 1'h0;
  end

  always @(negedge clk_in) if (sen_n_out && !pin_q) serial_data_in_out <= ~serial_data_in_out;

  task automatic pins(input logic c, input logic d);
    pin_q = 1'h1;
    sclk_out <= c;
    serial_data_in_out <= d;
  endtask

  task automatic frame(input logic [79:0] v, input int n, input int hi, input int lo,
                       input bit en);
    pin_q = 1'h0;
    // clock parks low before enable falls, so no stray falling edge
    @(posedge clk_in) sclk_out <= 1'h0;
    repeat (4) @(posedge clk_in);
    sen_n_out <= !en;
    repeat (4) @(posedge clk_in);
    for (int i = 79; i > 79 - n; i--) begin
      if (en) serial_data_in_out <= v[i];
      sclk_out <= 1'h1;
      // any duty, bit held over fall
      repeat (hi) @(posedge clk_in);
      sclk_out <= 1'h0;
      repeat (lo) @(posedge clk_in);
    end
    sen_n_out <= 1'h1;
  endtask
endmodule

// ===== testbench/acc_config_control_tb.sv
// Purpose: self-checking bench for acc_config_control
// Assumes: host model owns serial clock and data pins
// Notes:   expected settings come from an integer register model
`timescale 1ns/1ps
module acc_config_control_tb
  import acc_pkg::*;
;
  logic          clk_in    = 1'h0;
  logic          resetn_in = 1'h1;
  logic          en_q      = 1'h1;
  logic          par_q     = 1'h1;
  logic          rr_q      = 1'h0;
  logic          pdn_q     = 1'h0;
  acc_straps_t   st_q      = 8'h00;
  acc_settings_t set_w;
  logic          done_w;
  logic          sen_w;
  logic          sclk_w;
  logic          sdat_w;
  int            seed      = 50;
  int            bad_count = 0;
  int            checks    = 0;
  int            dones     = 0;
  int            want      = 0;
  int            r0        = 0;
  int            ra        = 0;
  int            rd        = 0;

  initial forever #50 clk_in = ~clk_in;

  acc_config_control u_dut (
    .clk_in(clk_in), .resetn_in(resetn_in), .clk_en_in(en_q),
    .parallel_mode_in(par_q), .reg_reset_in(rr_q), .serial_enable_n(sen_w),
    .serial_clk_in(sclk_w), .serial_data_in(sdat_w), .straps_in(st_q),
    .strap_reserved_in(2'h0), .pdn_pin_in(pdn_q), .settings_out(set_w),
    .write_done_out(done_w)
  );
  acc_host_model u_host (
    .clk_in(clk_in), .sen_n_out(sen_w), .sclk_out(sclk_w), .serial_data_in_out(sdat_w)
  );

  always @(posedge clk_in) if (done_w === 1'h1) dones++;

  function automatic acc_settings_t exp_set();
    acc_settings_t e;
    logic [1:0]    lv, fi, se, fo;
    bit            ov;
    e = '0;
    {lv, fi, se, fo} = st_q;
    ov = !par_q && rd[10];
    e.pdn_global = pdn_q || (par_q ? sclk_w && !sdat_w : r0[0]);
    e.pdn_channel = par_q ? 4'h0 : r0[4:1];
    e.ref_internal = par_q ? lv[1] : r0[5];
    e.gain_3p5db = par_q ? ^lv : ov && rd[5];
    e.two_wire = ov ? rd[0] : fi[1];
    e.ddr_clock = ov ? rd[1] : fi != 2'h2;
    e.ser_14x = ov ? rd[2] : ^se;
    e.capture_rise = (ov ? rd[4] : se[1]) && e.two_wire && !e.ddr_clock;
    e.lsb_first = ov ? rd[6] : fo[1];
    e.offset_binary = ov ? ra[10] : ^fo;
    e.byte_wise = ov && rd[7];
    e.pattern = PAT_NORMAL;
    if (par_q ? sdat_w && !sclk_w : ra[6:5] == 2'h1) e.pattern = PAT_SYNC;
    if (par_q ? sdat_w && sclk_w : ra[6:5] == 2'h2) e.pattern = PAT_DESKEW;
    return e;
  endfunction

  function automatic void put(input logic [15:0] w);
    if (w[15:11] == ADDR_MAIN && w[10]) begin
      r0 = 0;
      ra = 0;
      rd = 0;
    end
    else if (w[15:11] == ADDR_MAIN) r0 = w[10:0];
    else if (w[15:11] == ADDR_FORMAT) ra = w[10:0];
    else if (w[15:11] == ADDR_IFACE) rd = w[10:0];
  endfunction

  task automatic burst(input logic [79:0] v);
    for (int w = 0; w < 4; w++) put(v[79 - 16 * w -: 16]);
    want += 4;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    checks++;
    if (e !== s) begin
      bad_count++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask

  task automatic settle();
    repeat (8) @(posedge clk_in);
    chk("write_done count", want, dones);
    chk("settings_out", exp_set(), set_w);
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (100000) @(posedge clk_in);
    bad_count++;
    conclude();
  end

  initial begin
    logic [79:0] v;
    int          k;
    int          j;
    int          hi;
    acc_settings_t held;
    resetn_in <= 1'h0;
    repeat (20) @(posedge clk_in);
    resetn_in <= 1'h1;
    for (int i = 0; i < 24; i++) begin
      k = $random(seed);
      st_q <= k[7:0];
      pdn_q <= k[8] & k[9];
      u_host.pins(k[10], k[11]);
      settle();
    end
    $display("test pin mode done");
    par_q <= 1'h0;
    for (int i = 0; i < 6; i++) begin
      k = $random(seed);
      j = $random(seed);
      st_q <= j[7:0];
      pdn_q <= j[8] & j[9];
      hi = 2 + 2 * (i % 3);
      v = {ADDR_IFACE, k[10:0], ADDR_FORMAT, j[20:10], ADDR_MAIN, 1'h0, k[30:21],
           5'h05, j[31:21], k[15:0]};
      u_host.frame(v, 64 + 3 * i, hi, 8 - hi, i != 2);
      if (i != 2) burst(v);
      settle();
    end
    $display("test serial words done");
    held = exp_set();
    en_q <= 1'h0;
    pdn_q <= !pdn_q;
    repeat (8) @(posedge clk_in);
    chk("frozen settings_out", held, set_w);
    en_q <= 1'h1;
    settle();
    $display("test clock enable done");
    u_host.frame({ADDR_MAIN, 11'h400, 64'h0}, 16, 4, 4, 1'h1);
    put({ADDR_MAIN, 11'h400});
    want++;
    settle();
    u_host.frame(v, 64, 4, 4, 1'h1);
    burst(v);
    settle();
    rr_q <= 1'h1;
    @(posedge clk_in) rr_q <= 1'h0;
    put({ADDR_MAIN, 11'h400});
    settle();
    $display("test register reset done");
    conclude();
  end
endmodule
